// ---- tc16_pkg.sv ----
// Constants and types for the 16-bit timer counter with input capture
package tc16_pkg;
    // ************
    // Register map
    // ************
    localparam logic [3:0] ADR_CTRL_A = 4'h0;
    localparam logic [3:0] ADR_CTRL_B = 4'h1;
    localparam logic [3:0] ADR_CNT_LO = 4'h2;
    localparam logic [3:0] ADR_CNT_HI = 4'h3;
    localparam logic [3:0] ADR_CAP_LO = 4'h4;
    localparam logic [3:0] ADR_CAP_HI = 4'h5;
    localparam logic [3:0] ADR_CMPA_LO = 4'h6;
    localparam logic [3:0] ADR_CMPA_HI = 4'h7;
    localparam logic [3:0] ADR_FLAGS = 4'h8;
    localparam logic [3:0] ADR_MASK = 4'h9;
    localparam logic [3:0] ADR_CMP_CS = 4'ha;
    // ***************
    // Field positions
    // ***************
    localparam int CA_WGM_LSB = 0;
    localparam int CB_CS_LSB = 0;
    localparam int CB_WGM_LSB = 3;
    localparam int CB_EDGE = 6;
    localparam int CB_FILT = 7;
    localparam int FLG_OVF = 0;
    localparam int FLG_CAP = 5;
    localparam int CMP_SEL = 2;
    // *****************
    // Values and codes
    // *****************
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [15:0] CNT_BOTTOM = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [15:0] TOP8 = 16'h00ff;
    localparam logic [15:0] TOP9 = 16'h01ff;
    localparam logic [15:0] TOP10 = 16'h03ff;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;
    localparam int PRE_W = 10;
    localparam int FILT_SAMPLES = 4;
    typedef enum logic {TC16_UP, TC16_DOWN} tc16_dir_t;
    typedef struct packed {
        logic filt_en;
        logic edge_rise;
        logic [3:0] wgm;
        logic [2:0] cs;
    } tc16_cfg_t;
endpackage

// ---- tc16_src_model.sv ----
// Pulse source model for the capture trigger inputs
`timescale 1ns/1ps
`default_nettype none
module tc16_src_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic go,
    input wire logic inv,
    input wire logic [3:0] width,
    input wire logic [7:0] gap,
    input wire logic [1:0] num,
    output logic pin
);
    // ***********
    // Pulse train
    // ***********
    logic [1:0] n_r;
    logic [7:0] t_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            n_r <= 2'h0;
            t_r <= 8'h00;
        end else if (go) begin
            n_r <= num;
            t_r <= 8'h00;
        end else if (n_r != 2'h0) begin
            if (t_r == 8'(width) + gap - 8'h01) begin
                t_r <= 8'h00;
                n_r <= n_r - 2'h1;
            end else begin
                t_r <= t_r + 8'h01;
            end
        end
    end
    assign pin = inv ^ (n_r != 2'h0 && t_r < 8'(width));
endmodule
`default_nettype wire

// ---- tc16_timer.sv ----
// 16-bit up/down timer counter with input capture and 8-bit register port
`timescale 1ns/1ps
`default_nettype none
module tc16_timer #(
    parameter bit FIRST_INSTANCE = 1'b1,
    parameter int FILT_LEN = tc16_pkg::FILT_SAMPLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic capture_pin,
    input wire logic comparator_output,
    input wire logic ext_clk_pin,
    input wire logic ovf_irq_ack,
    input wire logic capture_irq_ack,
    output logic ovf_irq,
    output logic capture_irq,
    output logic count_top,
    output logic count_bottom
);
    import tc16_pkg::*;

    generate
        if (FILT_LEN < 2) begin : g_chk
            $error("FILT_LEN must be at least 2");
        end
    endgenerate

    // ******************
    // Registers and cfg
    // ******************
    logic [7:0] ctrl_a_r, ctrl_b_r, mask_r, cmp_cs_r, temp_r, rdata_r;
    logic [15:0] cnt_r, icr_r, ocra_r;
    tc16_dir_t dir_r, dir_nxt;
    logic [15:0] cnt_nxt;
    logic ovf_flag_r, cap_flag_r, ovf_irq_r, cap_irq_r;
    logic top_r, bottom_r;
    logic [PRE_W-1:0] pre_r;
    tc16_cfg_t cfg;

    assign cfg.filt_en = ctrl_b_r[CB_FILT];
    assign cfg.edge_rise = ctrl_b_r[CB_EDGE];
    assign cfg.wgm = {ctrl_b_r[CB_WGM_LSB+1:CB_WGM_LSB],
                      ctrl_a_r[CA_WGM_LSB+1:CA_WGM_LSB]};
    assign cfg.cs = ctrl_b_r[CB_CS_LSB+2:CB_CS_LSB];

    wire wr_cnt_lo = wr && (addr == ADR_CNT_LO);
    wire rd_cnt_lo = rd && (addr == ADR_CNT_LO);
    wire rd_cap_lo = rd && (addr == ADR_CAP_LO);
    wire wr_cap_lo = wr && (addr == ADR_CAP_LO);
    wire wr_hi = wr && (addr == ADR_CNT_HI || addr == ADR_CAP_HI ||
                        addr == ADR_CMPA_HI);
    wire wr_flags = wr && (addr == ADR_FLAGS);
    wire [7:0] cnt_hi = cnt_r[15:8];

    // ***************
    // Mode decoding
    // ***************
    wire icr_top = (cfg.wgm == 4'h8) || (cfg.wgm == 4'ha) ||
                   (cfg.wgm == 4'hc) || (cfg.wgm == 4'he);
    wire ocra_top = (cfg.wgm == 4'h4) || (cfg.wgm == 4'h9) ||
                    (cfg.wgm == 4'hb) || (cfg.wgm == 4'hf);
    wire dual = (cfg.wgm >= 4'h1 && cfg.wgm <= 4'h3) ||
                (cfg.wgm >= 4'h8 && cfg.wgm <= 4'hb);
    wire fast = (cfg.wgm >= 4'h5 && cfg.wgm <= 4'h7) ||
                (cfg.wgm == 4'he) || (cfg.wgm == 4'hf);
    wire [1:0] res = cfg.wgm[1:0];
    wire [15:0] fix_top = (res == 2'h1) ? TOP8 :
                          (res == 2'h2) ? TOP9 : TOP10;
    wire [15:0] top = icr_top ? icr_r :
                      ocra_top ? ocra_r :
                      (cfg.wgm[3] || cfg.wgm == 4'h0) ? CNT_MAX : fix_top;

    // ***************
    // Tick selection
    // ***************
    logic ext_s1_r, ext_s2_r, ext_s3_r;
    logic cap_s1_r, cap_s2_r, cmp_s1_r, cmp_s2_r;
    wire ext_rise = ext_s2_r && !ext_s3_r;
    wire ext_fall = !ext_s2_r && ext_s3_r;
    logic tick;
    always_comb begin
        case (cfg.cs)
            CS_STOP: tick = 1'b0;
            CS_DIV1: tick = 1'b1;
            CS_DIV8: tick = &pre_r[2:0];
            CS_DIV64: tick = &pre_r[5:0];
            CS_DIV256: tick = &pre_r[7:0];
            CS_DIV1024: tick = &pre_r[9:0];
            CS_EXT_FALL: tick = ext_fall;
            CS_EXT_RISE: tick = ext_rise;
            default: tick = 1'b0;
        endcase
    end

    // ***************
    // Counter unit
    // ***************
    always_comb begin
        cnt_nxt = cnt_r;
        dir_nxt = dir_r;
        if (wr_cnt_lo) begin
            cnt_nxt = {temp_r, wdata};
        end else if (tick) begin
            if (!dual) begin
                cnt_nxt = (cnt_r == top) ? CNT_BOTTOM : cnt_r + CNT_ONE;
            end else if (dir_r == TC16_UP) begin
                if (cnt_r >= top) begin
                    dir_nxt = TC16_DOWN;
                    cnt_nxt = cnt_r - CNT_ONE;
                end else begin
                    cnt_nxt = cnt_r + CNT_ONE;
                end
            end else if (cnt_r == CNT_BOTTOM) begin
                dir_nxt = TC16_UP;
                cnt_nxt = cnt_r + CNT_ONE;
            end else begin
                cnt_nxt = cnt_r - CNT_ONE;
            end
        end
    end

    wire ovf_at = dual ? (cnt_r == CNT_BOTTOM && dir_r == TC16_DOWN) :
                  fast ? (cnt_r == top) : (cnt_r == CNT_MAX);
    wire ovf_ev = tick && !wr_cnt_lo && ovf_at;

    // ******************
    // Capture front end
    // ******************
    logic [FILT_LEN-1:0] hist_r;
    logic filt_r, prev_r;
    wire raw_src = (FIRST_INSTANCE && cmp_cs_r[CMP_SEL]) ?
                   cmp_s2_r : cap_s2_r;
    wire hist_eq = (&hist_r) || !(|hist_r);
    wire sel_in = cfg.filt_en ? filt_r : raw_src;
    wire edge_hit = cfg.edge_rise ? (sel_in && !prev_r) :
                    (!sel_in && prev_r);
    wire cap_ev = edge_hit && !icr_top;

    // ***************
    // Flags and bus
    // ***************
    wire ovf_clr = (wr_flags && wdata[FLG_OVF]) || ovf_irq_ack;
    wire cap_clr = (wr_flags && wdata[FLG_CAP]) || capture_irq_ack;
    wire ovf_flag_nxt = ovf_ev || (ovf_flag_r && !ovf_clr);
    wire cap_flag_nxt = cap_ev || (cap_flag_r && !cap_clr);
    wire [7:0] flags_rd = 8'(ovf_flag_r) << FLG_OVF |
                          8'(cap_flag_r) << FLG_CAP;
    logic [7:0] rd_mux, temp_nxt;
    always_comb begin
        case (addr)
            ADR_CTRL_A: rd_mux = ctrl_a_r;
            ADR_CTRL_B: rd_mux = ctrl_b_r;
            ADR_CNT_LO: rd_mux = cnt_r[7:0];
            ADR_CNT_HI: rd_mux = temp_r;
            ADR_CAP_LO: rd_mux = icr_r[7:0];
            ADR_CAP_HI: rd_mux = temp_r;
            ADR_CMPA_LO: rd_mux = ocra_r[7:0];
            ADR_CMPA_HI: rd_mux = ocra_r[15:8];
            ADR_FLAGS: rd_mux = flags_rd;
            ADR_MASK: rd_mux = mask_r;
            ADR_CMP_CS: rd_mux = cmp_cs_r;
            default: rd_mux = BYTE_RST;
        endcase
    end
    always_comb begin
        temp_nxt = temp_r;
        if (wr_hi) begin
            temp_nxt = wdata;
        end else if (rd_cnt_lo) begin
            temp_nxt = cnt_r[15:8];
        end else if (rd_cap_lo) begin
            temp_nxt = icr_r[15:8];
        end
    end

    // ***************
    // Flip-flops
    // ***************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {ext_s1_r, ext_s2_r, ext_s3_r} <= 3'h0;
            {cap_s1_r, cap_s2_r, cmp_s1_r, cmp_s2_r} <= 4'h0;
            hist_r <= '0;
            filt_r <= 1'b0;
            prev_r <= 1'b0;
            pre_r <= '0;
        end else begin
            ext_s1_r <= ext_clk_pin;
            ext_s2_r <= ext_s1_r;
            ext_s3_r <= ext_s2_r;
            cap_s1_r <= capture_pin;
            cap_s2_r <= cap_s1_r;
            cmp_s1_r <= comparator_output;
            cmp_s2_r <= cmp_s1_r;
            hist_r <= {hist_r[FILT_LEN-2:0], raw_src};
            if (hist_eq) begin
                filt_r <= hist_r[0];
            end
            prev_r <= sel_in;
            pre_r <= pre_r + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {ctrl_a_r, ctrl_b_r, mask_r, cmp_cs_r} <= 32'h0;
            temp_r <= BYTE_RST;
            rdata_r <= BYTE_RST;
            cnt_r <= CNT_BOTTOM;
            dir_r <= TC16_UP;
        end else begin
            if (wr && addr == ADR_CTRL_A) ctrl_a_r <= wdata;
            if (wr && addr == ADR_CTRL_B) ctrl_b_r <= wdata;
            if (wr && addr == ADR_MASK) mask_r <= wdata;
            if (wr && addr == ADR_CMP_CS) cmp_cs_r <= wdata;
            temp_r <= temp_nxt;
            rdata_r <= rd ? rd_mux : BYTE_RST;
            cnt_r <= cnt_nxt;
            dir_r <= dir_nxt;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            icr_r <= CNT_BOTTOM;
            ocra_r <= CNT_BOTTOM;
            {ovf_flag_r, cap_flag_r, ovf_irq_r, cap_irq_r} <= 4'h0;
            {top_r, bottom_r} <= 2'h0;
        end else begin
            if (cap_ev) begin
                icr_r <= cnt_r;
            end else if (wr_cap_lo && icr_top) begin
                icr_r <= {temp_r, wdata};
            end
            if (wr && addr == ADR_CMPA_LO) ocra_r <= {temp_r, wdata};
            ovf_flag_r <= ovf_flag_nxt;
            cap_flag_r <= cap_flag_nxt;
            ovf_irq_r <= ovf_flag_nxt && mask_r[FLG_OVF];
            cap_irq_r <= cap_flag_nxt && mask_r[FLG_CAP];
            top_r <= (cnt_nxt == top);
            bottom_r <= (cnt_nxt == CNT_BOTTOM);
        end
    end

    assign rdata = rdata_r;
    assign ovf_irq = ovf_irq_r;
    assign capture_irq = cap_irq_r;
    assign count_top = top_r;
    assign count_bottom = bottom_r;

    // ***************
    // Assertions
    // ***************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_CNT_WRITE: assert property (
        wr_cnt_lo |=> cnt_r == {$past(temp_r), $past(wdata)})
        else $error("counter low write did not load staged value");
    AST_WRITE_WINS: assert property (
        wr_cnt_lo && tick |=> cnt_r == {$past(temp_r), $past(wdata)})
        else $error("count overrode cpu write");
    AST_STAGE_CNT: assert property (
        rd_cnt_lo |=> temp_r == $past(cnt_hi) ##1 1'b1)
        else $error("staging byte not loaded on counter low read");
    AST_STOPPED: assert property (
        cfg.cs == CS_STOP && !wr_cnt_lo |=> cnt_r == $past(cnt_r))
        else $error("counter moved while stopped");
    AST_NORMAL_INC: assert property (
        tick && cfg.wgm == 4'h0 && !wr_cnt_lo
        |=> cnt_r == $past(cnt_r) + CNT_ONE)
        else $error("normal mode did not increment by one");
    AST_CAPTURE: assert property (
        cap_ev |=> icr_r == $past(cnt_r) && cap_flag_r)
        else $error("capture did not copy counter and set flag");
    AST_CAP_OFF: assert property (
        icr_top |-> !cap_ev)
        else $error("capture fired in capture-top mode");
    AST_CAP_CLEAR: assert property (
        cap_flag_r && cap_clr && !cap_ev |=> !cap_flag_r)
        else $error("capture flag not cleared");
    AST_OVF_SET: assert property (
        ovf_ev |=> ovf_flag_r ##1 1'b1)
        else $error("overflow flag not set");
    AST_FILTER: assert property (
        cfg.filt_en && filt_r != $past(filt_r) |-> $past(hist_eq))
        else $error("filter changed without equal samples");
    AST_ICR_LOCK: assert property (
        wr_cap_lo && !icr_top && !cap_ev |=> $stable(icr_r))
        else $error("capture register written outside top mode");

    COV_CAPTURE: cover property (cap_ev ##1 cap_irq_r);
    COV_OVERFLOW: cover property (ovf_ev ##1 ovf_irq_r);
    COV_WR_TICK: cover property (wr_cnt_lo && tick);
    COV_TURN: cover property (dir_r == TC16_UP ##1 dir_r == TC16_DOWN);
endmodule
`default_nettype wire

// ---- tc16_timer_test.sv ----
// Self-checking bench for the 16-bit timer counter
`timescale 1ns/1ps
`default_nettype none
module tc16_timer_test;
    import tc16_pkg::*;
    // *******
    // Signals
    // *******
    localparam int LIMIT = 5000;
    logic clk, rst_n, wr, rd, raw, rd_q, raw_q;
    logic [3:0] addr, width;
    logic [7:0] wdata, gap, lo_b, hi_b;
    logic [1:0] num;
    logic cap_go, cmp_go, cap_inv, ovf_ack, cap_ack, ext_clk;
    wire [7:0] rdata;
    wire capture_pin, comparator_output, ovf_irq, capture_irq;
    wire count_top, count_bottom;
    logic [7:0] q[$];
    logic [15:0] v;
    int i, err_count, checked, cyc_n;
    integer seed;
    tc16_timer u_dut (.clk(clk), .rst_n(rst_n), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .capture_pin(capture_pin), .comparator_output(comparator_output),
        .ext_clk_pin(ext_clk), .ovf_irq_ack(ovf_ack),
        .capture_irq_ack(cap_ack), .ovf_irq(ovf_irq),
        .capture_irq(capture_irq), .count_top(count_top),
        .count_bottom(count_bottom));
    tc16_src_model u_cap (.clk(clk), .rst_n(rst_n), .go(cap_go),
        .inv(cap_inv), .width(width), .gap(gap), .num(num),
        .pin(capture_pin));
    tc16_src_model u_cmp (.clk(clk), .rst_n(rst_n), .go(cmp_go),
        .inv(1'b0), .width(width), .gap(gap), .num(num),
        .pin(comparator_output));
    always #25 clk = ~clk;
    // *****
    // Tasks
    // *****
    task chk(input string s, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", s, e, g);
        end
    endtask
    task report_and_stop;
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task bus(input logic w, input logic x, input logic [3:0] a,
             input logic [7:0] d);
        wr <= w;
        rd <= !w;
        raw <= x;
        addr <= a;
        wdata <= d;
        @(posedge clk);
    endtask
    task idle(input int n);
        wr <= 1'b0;
        rd <= 1'b0;
        raw <= 1'b0;
        repeat (n) @(posedge clk);
    endtask
    task wx(input logic [3:0] a, input logic [7:0] d);
        bus(1'b1, 1'b0, a, d);
    endtask
    task rx(input logic [3:0] a, input logic [7:0] e);
        q.push_back(e);
        bus(1'b0, 1'b0, a, 8'h00);
    endtask
    task rraw(input logic [3:0] a, output logic [7:0] b);
        bus(1'b0, 1'b1, a, 8'h00);
        idle(0);
        @(negedge clk);
        b = rdata;
        @(posedge clk);
    endtask
    task w16(input logic [3:0] ha, input logic [15:0] d);
        wx(ha, d[15:8]);
        wx(ha - 4'h1, d[7:0]);
    endtask
    task r16(input logic [3:0] la, input logic [15:0] e);
        rx(la, e[7:0]);
        rx(la + 4'h1, e[15:8]);
        idle(1);
    endtask
    task pk(input string s, input logic e, input int k);
        idle(0);
        @(negedge clk);
        chk(s, 16'(e), 16'(k == 0 ? count_bottom : k == 1 ? count_top :
            k == 2 ? capture_irq : ovf_irq));
        @(posedge clk);
    endtask
    task expcap(input logic c);
        rx(ADR_FLAGS, c ? 8'h20 : 8'h00);
        wx(ADR_FLAGS, 8'h20);
        idle(1);
    endtask
    task pulse(input logic c, input logic [3:0] w, input logic [7:0] g,
               input logic [1:0] n);
        width <= w;
        gap <= g;
        num <= n;
        cap_go <= !c;
        cmp_go <= c;
        idle(1);
        cap_go <= 1'b0;
        cmp_go <= 1'b0;
        idle(16);
    endtask
    task src_change;
        idle(10);
        wx(ADR_FLAGS, 8'h20);
    endtask
    // *******
    // Checker
    // *******
    always @(posedge clk) begin
        rd_q <= rd;
        raw_q <= raw;
        cyc_n <= cyc_n + 1;
        if (cyc_n == LIMIT) begin
            err_count++;
            report_and_stop;
        end
    end
    always @(negedge clk) begin
        if (rd_q && !raw_q) begin
            if (q.size() == 0) chk("read queue", 16'h0001, 16'h0000);
            else chk("rdata", 16'(q.pop_front()), 16'(rdata));
        end
    end
    // ********
    // Sequence
    // ********
    initial begin
        seed = 17423;
        clk = 0; rst_n = 0; wr = 0; rd = 0; raw = 0; addr = 0; wdata = 0;
        cap_go = 0; cmp_go = 0; cap_inv = 0; width = 0; gap = 0; num = 0;
        ovf_ack = 0; cap_ack = 0; ext_clk = 0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        idle(1);
        pk("bottom", 1'b1, 0);
        for (i = 0; i < 16; i++) rx(4'(i), 8'h00);
        wx(4'hc, 8'h5a);
        rx(4'hc, 8'h00);
        v = 16'($random(seed));
        w16(ADR_CNT_HI, v);
        r16(ADR_CNT_LO, v);
        w16(ADR_CNT_HI, 16'h12ff);
        rx(ADR_CNT_LO, 8'hff);
        wx(ADR_CTRL_B, 8'h01);
        idle(10);
        wx(ADR_CTRL_B, 8'h00);
        rx(ADR_CNT_HI, 8'h12);
        rraw(ADR_CNT_LO, lo_b);
        idle(10);
        rx(ADR_CNT_LO, lo_b);
        w16(ADR_CNT_HI, 16'h3456);
        wx(ADR_MASK, 8'h20);
        wx(ADR_FLAGS, 8'h20);
        pulse(1'b0, 4'h3, 8'h01, 2'h1);
        pk("capture irq", 1'b1, 2);
        expcap(1'b1);
        pk("capture irq", 1'b0, 2);
        r16(ADR_CAP_LO, 16'h3456);
        w16(ADR_CNT_HI, 16'h789a);
        pulse(1'b0, 4'h3, 8'h01, 2'h1);
        cap_ack <= 1'b1;
        idle(1);
        cap_ack <= 1'b0;
        pk("capture irq", 1'b0, 2);
        rx(ADR_FLAGS, 8'h00);
        r16(ADR_CAP_LO, 16'h789a);
        wx(ADR_CTRL_B, 8'h18);
        w16(ADR_CAP_HI, 16'h0abc);
        r16(ADR_CAP_LO, 16'h0abc);
        pulse(1'b0, 4'h3, 8'h01, 2'h1);
        expcap(1'b0);
        r16(ADR_CAP_LO, 16'h0abc);
        wx(ADR_CTRL_B, 8'h00);
        w16(ADR_CAP_HI, 16'h1122);
        r16(ADR_CAP_LO, 16'h0abc);
        cap_inv <= 1'b1;
        idle(12);
        expcap(1'b0);
        cap_inv <= 1'b0;
        idle(12);
        expcap(1'b1);
        wx(ADR_CTRL_B, 8'h40);
        wx(ADR_FLAGS, 8'h20);
        cap_inv <= 1'b1;
        idle(12);
        expcap(1'b1);
        for (i = 0; i < 3; i++) begin
            wx(ADR_CTRL_B, i < 2 ? 8'hc0 : 8'h40);
            src_change();
            pulse(1'b0, i == 1 ? 4'h6 : 4'h2, 8'h01, 2'h1);
            expcap(i != 0);
        end
        pulse(1'b1, 4'h3, 8'h01, 2'h1);
        expcap(1'b0);
        wx(ADR_CMP_CS, 8'h04);
        src_change();
        pulse(1'b1, 4'h3, 8'h01, 2'h1);
        expcap(1'b1);
        wx(ADR_CMP_CS, 8'h00);
        cap_inv <= 1'b0;
        src_change();
        wx(ADR_CTRL_B, 8'h41);
        pulse(1'b0, 4'h2, 8'h3a, 2'h2);
        rraw(ADR_CAP_LO, lo_b);
        rraw(ADR_CAP_HI, hi_b);
        idle(70);
        r16(ADR_CAP_LO, {hi_b, lo_b} + 16'h003c);
        wx(ADR_CTRL_B, 8'h00);
        w16(ADR_CNT_HI, 16'hfffd);
        wx(ADR_FLAGS, 8'h21);
        wx(ADR_MASK, 8'h21);
        wx(ADR_CTRL_B, 8'h01);
        idle(10);
        wx(ADR_CTRL_B, 8'h00);
        pk("overflow irq", 1'b1, 3);
        rx(ADR_FLAGS, 8'h01);
        ovf_ack <= 1'b1;
        idle(1);
        ovf_ack <= 1'b0;
        pk("overflow irq", 1'b0, 3);
        w16(ADR_CNT_HI, 16'hffff);
        idle(2);
        pk("top", 1'b1, 1);
        w16(ADR_CNT_HI, 16'h0000);
        idle(2);
        pk("bottom", 1'b1, 0);
        wx(ADR_CNT_HI, 8'h5a);
        wx(ADR_CMPA_LO, 8'h01);
        wx(ADR_CNT_LO, 8'h02);
        r16(ADR_CMPA_LO, 16'h5a01);
        r16(ADR_CNT_LO, 16'h5a02);
        w16(ADR_CNT_HI, 16'h0100);
        for (i = 6; i < 8; i++) begin
            wx(ADR_CTRL_B, 8'(i));
            repeat (3) begin
                ext_clk <= 1'b1;
                idle(4);
                ext_clk <= 1'b0;
                idle(4);
            end
            wx(ADR_CTRL_B, 8'h00);
        end
        r16(ADR_CNT_LO, 16'h0106);
        wx(ADR_CTRL_B, 8'h01);
        w16(ADR_CNT_HI, 16'h4000);
        wx(ADR_CTRL_B, 8'h00);
        r16(ADR_CNT_LO, 16'h4001);
        w16(ADR_CNT_HI, 16'h00fe);
        wx(ADR_CTRL_A, 8'h01);
        wx(ADR_CTRL_B, 8'h01);
        idle(3);
        wx(ADR_CTRL_B, 8'h00);
        wx(ADR_CTRL_A, 8'h00);
        r16(ADR_CNT_LO, 16'h00fc);
        idle(2);
        report_and_stop;
    end
endmodule
`default_nettype wire
